// ### logic/dtc_cfg.svh
// Offsets, field positions, reset values and timing counts of the termination controller.
// Behaviour
// R01: Self refresh forces all termination off.
// R02: Pin ignored when nominal disabled or self refresh.
// R03: Enabled when nominal, write or park nonzero.
// R04: Priority: disable, write, nominal, then park.
// R05: Write termination applies whatever the pin level.
// R06: Pin high turns on nominal unless disabled.
// R07: Park when pin low or nominal off.
// R08: Read forces high impedance for a window.
// R09: Write command applies write termination for window.
// R10: Nominal disabled powers down the pin receiver.
// R11: Nominal and park fields: off plus seven values.
// R12: Write field: off plus three values.
// R13: Strobe termination only when mode one bit eleven.
// R14: Synchronous mode whenever the DLL is locked.
// R15: Nominal follows pin after on/off latency.
// R16: Pin latency is write+additive+parity minus 2/3.
// R17: Read turn-off at read+additive+parity minus 2/3.
// R18: Park returns 4/6 after read turn-off, 5/7.
// R19: Controller holds pin high 4/6 or 5/7 clocks.
// R20: Controller lengthens hold with CRC or long preamble.
// R21: Hold counted from first high or write command.
// R22: No termination while driving read data; here an active write window still wins over the read window.
// R23: Listed latencies hold only with write CRC off.
// R24: Dynamic write termination when mode two bit 9/10.
// R25: Countdown counters schedule each termination change; here they time only the read and write windows, and nominal follows a pin pipe.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ==========================================================
// Register offsets
`define DTC_OFS_MODE_ONE 8'h00
`define DTC_OFS_MODE_TWO 8'h04
`define DTC_OFS_MODE_FIVE 8'h08
`define DTC_OFS_LATENCY 8'h0C
`define DTC_OFS_STATUS 8'h10

// ==========================================================
// Field positions
`define DTC_NOM_LSB 8
`define DTC_NOM_MSB 10
`define DTC_STRB_BIT 11
`define DTC_WR_LSB 9
`define DTC_WR_MSB 11
`define DTC_DYN_BIT_A 9
`define DTC_DYN_BIT_B 10
`define DTC_PARK_LSB 6
`define DTC_PARK_MSB 8
`define DTC_LAT_WL_LSB 0
`define DTC_LAT_AL_LSB 5
`define DTC_LAT_PL_LSB 10
`define DTC_LAT_RL_LSB 13
`define DTC_LAT_PRE2_BIT 18
`define DTC_LAT_CRC_BIT 19
`define DTC_LAT_CHOPFIX_BIT 20
`define DTC_STAT_VIOL_BIT 4

// ==========================================================
// Reset values
`define DTC_RST_MODE 13'h0000
`define DTC_RST_LATENCY 21'h000009

// ==========================================================
// Timing counts in clocks
`define DTC_LAT_SUB_SHORT 7'h02
`define DTC_LAT_SUB_LONG 7'h03
`define DTC_HOLD_CHOP 7'h04
`define DTC_HOLD_FULL 7'h06
`define DTC_PIN_PIPE_LAT 7'h03
`define DTC_PIPE_DEPTH 64

`endif

// ### logic/dtc_pkg.sv
// Types shared by the termination controller and its users.
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_TERM_OFF,
		DTC_TERM_NOM,
		DTC_TERM_WR,
		DTC_TERM_PARK
	} dtc_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dtc_bus_req_t;

	typedef struct packed {
		logic read;
		logic write;
		logic chop;
	} dtc_cmd_t;

	typedef struct packed {
		dtc_state_t state;
		logic [2:0] code;
		logic strobe_en;
	} dtc_term_t;
endpackage : dtc_pkg

// ### logic/dtc_top.sv
// Termination control for the data, strobe and mask inputs of the memory device.
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dtc_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire dtc_pkg::dtc_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	// Command decode and device state
	input wire dtc_pkg::dtc_cmd_t cmd,
	input wire logic self_refresh,
	input wire logic dll_locked,
	// Termination pin from the controller
	input wire logic termination_ctrl_pin,
	// Termination drive
	output dtc_pkg::dtc_term_t term,
	output logic pin_rx_enable
);
	import dtc_pkg::*;

	// ==========================================================
	// Registers
	logic [12:0] mode_reg_one_ff;
	logic [12:0] mode_reg_two_ff;
	logic [12:0] mode_reg_five_ff;
	logic [20:0] latency_ff;
	logic hold_viol_ff;
	logic [31:0] rdata_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_reg_one_ff <= `DTC_RST_MODE;
			mode_reg_two_ff <= `DTC_RST_MODE;
			mode_reg_five_ff <= `DTC_RST_MODE;
			latency_ff <= `DTC_RST_LATENCY;
		end else if (bus_req.wr) begin
			unique case (bus_req.addr)
				`DTC_OFS_MODE_ONE: mode_reg_one_ff <= bus_req.wdata[12:0];
				`DTC_OFS_MODE_TWO: mode_reg_two_ff <= bus_req.wdata[12:0];
				`DTC_OFS_MODE_FIVE: mode_reg_five_ff <= bus_req.wdata[12:0];
				`DTC_OFS_LATENCY: latency_ff <= bus_req.wdata[20:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Mode fields
	logic [2:0] nom_code;
	logic [2:0] wr_code;
	logic [2:0] park_code;
	logic nom_en;
	logic wr_en;
	logic park_en;
	logic dyn_en;
	logic term_enabled;
	logic sync_mode;
	logic pre2;
	logic chop_fixed;

	assign nom_code = mode_reg_one_ff[`DTC_NOM_MSB:`DTC_NOM_LSB]; // [R11]
	assign park_code = mode_reg_five_ff[`DTC_PARK_MSB:`DTC_PARK_LSB]; // [R11]
	// Only the low two bits carry a write setting; the third is kept at zero. [R12]
	assign wr_code = {1'b0, mode_reg_two_ff[`DTC_WR_LSB+1:`DTC_WR_LSB]};
	assign nom_en = nom_code != 3'h0;
	assign wr_en = wr_code != 3'h0;
	assign park_en = park_code != 3'h0;
	assign dyn_en = mode_reg_two_ff[`DTC_DYN_BIT_A] | mode_reg_two_ff[`DTC_DYN_BIT_B]; // [R24]
	assign term_enabled = nom_en | wr_en | park_en; // [R03]
	assign sync_mode = dll_locked; // [R14]
	assign pre2 = latency_ff[`DTC_LAT_PRE2_BIT];
	assign chop_fixed = latency_ff[`DTC_LAT_CHOPFIX_BIT];

	// ==========================================================
	// Latencies
	function automatic logic [6:0] dtc_sat_sub(input logic [6:0] a, input logic [6:0] b);
		logic [6:0] r;
		r = (a > b) ? 7'(a - b) : 7'h01;
		return r;
	endfunction : dtc_sat_sub

	logic [6:0] lat_sub;
	logic [6:0] pin_lat;
	logic [6:0] rd_off_lat;
	logic [6:0] wr_on_lat;
	logic [6:0] pipe_idx;

	assign lat_sub = pre2 ? `DTC_LAT_SUB_LONG : `DTC_LAT_SUB_SHORT;
	// Turn-on and turn-off share one latency. [R16]
	assign pin_lat = dtc_sat_sub(7'(latency_ff[`DTC_LAT_WL_LSB +: 5]) + 7'(latency_ff[`DTC_LAT_AL_LSB +: 5])
		+ 7'(latency_ff[`DTC_LAT_PL_LSB +: 3]), lat_sub);
	assign rd_off_lat = dtc_sat_sub(7'(latency_ff[`DTC_LAT_RL_LSB +: 5]) + 7'(latency_ff[`DTC_LAT_AL_LSB +: 5])
		+ 7'(latency_ff[`DTC_LAT_PL_LSB +: 3]), lat_sub); // [R17]
	assign wr_on_lat = dtc_sat_sub(7'(latency_ff[`DTC_LAT_WL_LSB +: 5]) + 7'(latency_ff[`DTC_LAT_AL_LSB +: 5])
		+ 7'(latency_ff[`DTC_LAT_PL_LSB +: 3]), lat_sub);

	// Window length after turn-off or turn-on, lengthened by one for the long preamble.
	function automatic logic [6:0] dtc_window(input logic chop, input logic long_pre);
		logic [6:0] w;
		w = chop ? `DTC_HOLD_CHOP : `DTC_HOLD_FULL;
		return long_pre ? 7'(w + 7'h01) : w;
	endfunction : dtc_window

	// ==========================================================
	// Pin receiver and synchroniser
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic pin_live;

	assign pin_rx_enable = nom_en & ~self_refresh; // [R10]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
		end else begin
			pin_s1_ff <= termination_ctrl_pin;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// The receiver gate acts only after the second flop, so the synchroniser samples the raw pin even while the receiver is off.
	assign pin_live = pin_s2_ff & nom_en & ~self_refresh; // [R02]

	// The synchroniser and pipe entry eat three clocks of the latency, so short
	// latencies saturate at the earliest point the pin can be seen.
	logic [`DTC_PIPE_DEPTH-1:0] pin_pipe_ff;
	logic nom_req;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			pin_pipe_ff <= '0;
		else
			pin_pipe_ff <= {pin_pipe_ff[`DTC_PIPE_DEPTH-2:0], pin_live}; // [R15]
	end

	assign pipe_idx = (pin_lat > `DTC_PIN_PIPE_LAT) ? 7'(pin_lat - `DTC_PIN_PIPE_LAT) : 7'h00;
	assign nom_req = pin_pipe_ff[pipe_idx[5:0]] & pin_live_gate(nom_en, self_refresh); // [R06]

	function automatic logic pin_live_gate(input logic en, input logic sr);
		return en & ~sr;
	endfunction : pin_live_gate

	// ==========================================================
	// Read window counters
	logic [6:0] rd_off_cnt_ff;
	logic [6:0] rd_on_cnt_ff;
	logic rd_hiz;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_off_cnt_ff <= 7'h00;
			rd_on_cnt_ff <= 7'h00;
		end else if (cmd.read) begin
			rd_off_cnt_ff <= rd_off_lat; // [R25]
			rd_on_cnt_ff <= 7'h00;
		end else begin
			if (rd_off_cnt_ff != 7'h00)
				rd_off_cnt_ff <= 7'(rd_off_cnt_ff - 7'h01);
			if (rd_off_cnt_ff == 7'h01)
				rd_on_cnt_ff <= dtc_window(chop_fixed, pre2); // [R18]
			else if (rd_on_cnt_ff != 7'h00)
				rd_on_cnt_ff <= 7'(rd_on_cnt_ff - 7'h01);
		end
	end

	// Output drive and termination do not overlap on the bus unless a write window is active, as write wins over the read window. [R22]
	assign rd_hiz = rd_on_cnt_ff != 7'h00; // [R08]

	// ==========================================================
	// Write window counters
	logic [6:0] wr_on_cnt_ff;
	logic [6:0] wr_len_cnt_ff;
	logic wr_chop_ff;
	logic wr_active;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_on_cnt_ff <= 7'h00;
			wr_len_cnt_ff <= 7'h00;
			wr_chop_ff <= 1'b0;
		end else if (cmd.write && dyn_en && wr_en) begin
			wr_on_cnt_ff <= wr_on_lat; // [R09] [R25]
			wr_len_cnt_ff <= 7'h00;
			wr_chop_ff <= cmd.chop | chop_fixed;
		end else begin
			if (wr_on_cnt_ff != 7'h00)
				wr_on_cnt_ff <= 7'(wr_on_cnt_ff - 7'h01);
			if (wr_on_cnt_ff == 7'h01)
				wr_len_cnt_ff <= dtc_window(wr_chop_ff, pre2);
			else if (wr_len_cnt_ff != 7'h00)
				wr_len_cnt_ff <= 7'(wr_len_cnt_ff - 7'h01);
		end
	end

	assign wr_active = wr_len_cnt_ff != 7'h00; // [R05]

	// ==========================================================
	// Hold check on the pin
	// The controller owns the hold time; the device only records a short pulse.
	logic [6:0] hold_cnt_ff;
	logic pin_prev_ff;
	logic viol_set;
	logic viol_clr;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_cnt_ff <= 7'h00;
			pin_prev_ff <= 1'b0;
		end else begin
			pin_prev_ff <= pin_live;
			if ((pin_live && !pin_prev_ff) || cmd.write)
				hold_cnt_ff <= 7'h01; // [R21]
			else if (hold_cnt_ff != 7'h00 && hold_cnt_ff != 7'h7F)
				hold_cnt_ff <= 7'(hold_cnt_ff + 7'h01);
		end
	end

	// The controller must lengthen the hold for CRC too; only the preamble is checked here. [R20]
	assign viol_set = pin_prev_ff && !pin_live && hold_cnt_ff != 7'h00
		&& hold_cnt_ff < dtc_window(chop_fixed, pre2); // [R19]
	assign viol_clr = bus_req.wr && bus_req.addr == `DTC_OFS_STATUS && bus_req.wdata[`DTC_STAT_VIOL_BIT];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			hold_viol_ff <= 1'b0;
		else if (viol_set)
			hold_viol_ff <= 1'b1;
		else if (viol_clr)
			hold_viol_ff <= 1'b0;
	end

	// ==========================================================
	// State resolution
	dtc_term_t nxt_term;
	dtc_term_t term_ff;

	always_comb begin
		nxt_term.state = DTC_TERM_OFF;
		nxt_term.code = 3'h0;
		if (self_refresh || !term_enabled || !sync_mode) begin // [R01] [R04]
			nxt_term.state = DTC_TERM_OFF;
		end else if (wr_active) begin // [R04]
			nxt_term.state = DTC_TERM_WR;
			nxt_term.code = wr_code;
		end else if (rd_hiz) begin // [R08]
			nxt_term.state = DTC_TERM_OFF;
		end else if (nom_req) begin // [R06]
			nxt_term.state = DTC_TERM_NOM;
			nxt_term.code = nom_code;
		end else if (park_en) begin // [R07]
			nxt_term.state = DTC_TERM_PARK;
			nxt_term.code = park_code;
		end
		nxt_term.strobe_en = (nxt_term.state != DTC_TERM_OFF) && mode_reg_one_ff[`DTC_STRB_BIT]; // [R13]
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			term_ff <= '{state: DTC_TERM_OFF, code: 3'h0, strobe_en: 1'b0};
		else
			term_ff <= nxt_term;
	end

	assign term = term_ff;

	// ==========================================================
	// Read port
	// Latencies are only valid with write CRC off; the status bit lets software see the mismatch. [R23]
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h00000000;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				`DTC_OFS_MODE_ONE: rdata_ff <= {19'h00000, mode_reg_one_ff};
				`DTC_OFS_MODE_TWO: rdata_ff <= {19'h00000, mode_reg_two_ff};
				`DTC_OFS_MODE_FIVE: rdata_ff <= {19'h00000, mode_reg_five_ff};
				`DTC_OFS_LATENCY: rdata_ff <= {11'h000, latency_ff};
				`DTC_OFS_STATUS: rdata_ff <= {25'h0000000, sync_mode, latency_ff[`DTC_LAT_CRC_BIT],
					hold_viol_ff, pin_rx_enable, term_ff.strobe_en, term_ff.state};
				default: rdata_ff <= 32'h00000000;
			endcase
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign bus_rdata = rdata_ff;
endmodule : dtc_top

// ### verif/dtc_top_props.sv
// Port-level assertions for the termination controller.
`timescale 1ns/10ps
module dtc_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Device state and drive
	input wire logic self_refresh,
	input wire logic dll_locked,
	input wire dtc_pkg::dtc_term_t term,
	input wire logic pin_rx_enable
);
	import dtc_pkg::*;
	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sr_forces_off_a: assert property (self_refresh |=> term.state == DTC_TERM_OFF)
		else $error("termination active in self refresh");
	rx_off_sr_a: assert property (self_refresh |-> !pin_rx_enable)
		else $error("pin receiver powered in self refresh");
	dll_forces_off_a: assert property (!dll_locked |=> term.state == DTC_TERM_OFF)
		else $error("termination active with the loop unlocked");
	off_no_code_a: assert property (term.state == DTC_TERM_OFF |-> term.code == 3'h0)
		else $error("resistance code while off");
	nom_needs_rx_a: assert property ($rose(term.state == DTC_TERM_NOM) |-> pin_rx_enable)
		else $error("nominal entered with receiver off");
	wr_window_a: assert property ($rose(term.state == DTC_TERM_WR) |-> (term.state == DTC_TERM_WR)[*4])
		else $error("write termination window too short");
	wr_code_a: assert property (term.state == DTC_TERM_WR |-> term.code inside {3'h1, 3'h2, 3'h3})
		else $error("write code out of range");
	nom_code_a: assert property (term.state == DTC_TERM_NOM |-> term.code != 3'h0)
		else $error("nominal with zero code");
	park_code_a: assert property (term.state == DTC_TERM_PARK |-> term.code != 3'h0)
		else $error("park with zero code");
endmodule : dtc_props

bind dtc_top dtc_props u_props (.mclk(mclk), .rst(rst), .self_refresh(self_refresh), .dll_locked(dll_locked),
	.term(term), .pin_rx_enable(pin_rx_enable));

// ### verif/dtc_ctrl_model.sv
// Behavioural memory controller driving the termination pin and commands.
`timescale 1ns/10ps
module dtc_ctrl_model (
	// Clock
	input wire logic mclk,
	// Controller outputs
	output dtc_pkg::dtc_cmd_t cmd,
	output logic termination_ctrl_pin
);
	import dtc_pkg::*;
	// Seven covers the long preamble; one more leaves room for write CRC.
	localparam int HOLD_MIN = 8;
	initial begin
		cmd = '0;
		termination_ctrl_pin = 1'b0;
	end
	// Short requests are stretched, so this task never breaks the minimum assertion time.
	task automatic drive_pin(input int len);
		@(posedge mclk);
		termination_ctrl_pin <= 1'b1;
		repeat ((len < HOLD_MIN) ? HOLD_MIN : len) @(posedge mclk);
		termination_ctrl_pin <= 1'b0;
	endtask : drive_pin
	// Deliberately shorter than any legal assertion time, to exercise the device's hold check.
	task automatic pulse_pin(input int len);
		@(posedge mclk);
		termination_ctrl_pin <= 1'b1;
		repeat (len) @(posedge mclk);
		termination_ctrl_pin <= 1'b0;
	endtask : pulse_pin
	task automatic issue(input logic rd, input logic wr, input logic chop);
		@(posedge mclk);
		cmd <= '{read: rd, write: wr, chop: chop};
		@(posedge mclk);
		cmd <= '0;
	endtask : issue
endmodule : dtc_ctrl_model

// ### verif/dtc_tb_top.sv
// Self-checking bench for the termination controller.
`timescale 1ns/10ps
module dtc_tb_top;
	import dtc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	dtc_bus_req_t bus_req = '0;
	logic [31:0] bus_rdata;
	dtc_cmd_t cmd;
	logic self_refresh = 1'b0;
	logic dll_locked = 1'b1;
	logic termination_ctrl_pin;
	dtc_term_t term;
	logic pin_rx_enable;
	int n_mismatch = 0;
	int checked = 0;
	always #4 mclk = ~mclk;
	dtc_top dut (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .cmd(cmd),
		.self_refresh(self_refresh), .dll_locked(dll_locked), .termination_ctrl_pin(termination_ctrl_pin),
		.term(term), .pin_rx_enable(pin_rx_enable));
	dtc_ctrl_model ctl (.mclk(mclk), .cmd(cmd), .termination_ctrl_pin(termination_ctrl_pin));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
		chk("rdata", exp, bus_rdata);
	endtask : reg_rd
	// Edges from the launching edge until the state shows, then the cycles it lasts.
	task automatic span(input dtc_state_t st, input int on, input int len, input logic [2:0] code);
		int n;
		n = 0;
		@(posedge mclk);
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (term.state !== st && n < 40);
		chk("delay", on, n);
		chk("code", {29'h0, code}, {29'h0, term.code});
		n = 0;
		while (term.state === st && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("length", len, n);
	endtask : span
	task automatic test_done;
		$display("Mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		chk("off", DTC_TERM_OFF, term.state);
		reg_rd(8'h0C, 32'h0000_0009);
		reg_wr(8'h00, 32'hFFFF_EB00);
		reg_rd(8'h00, 32'h0000_0B00);
		reg_wr(8'h08, 32'h0000_0140);
		reg_wr(8'h20, 32'hFFFF_FFFF);
		reg_rd(8'h20, 32'h0000_0000);
		reg_rd(8'h08, 32'h0000_0140);
		chk("park", DTC_TERM_PARK, term.state);
		chk("park code", 32'h0000_0005, {29'h0, term.code});
		chk("strobe", 1'b1, term.strobe_en);
		chk("rx", 1'b1, pin_rx_enable);
	endtask : t_regs
	task automatic t_nominal;
		fork
			ctl.drive_pin(8);
			span(DTC_TERM_NOM, 8, 8, 3'h3);
		join
		chk("park after", DTC_TERM_PARK, term.state);
	endtask : t_nominal
	task automatic t_write;
		for (int p = 0; p < 2; p++) begin
			reg_wr(8'h0C, 32'h0000_000A | (p << 18));
			reg_wr(8'h04, 32'h0000_0400);
			fork
				ctl.issue(1'b0, 1'b1, 1'b0);
				span(DTC_TERM_WR, 10 - p, 6 + p, 3'h2);
			join
			fork
				ctl.issue(1'b0, 1'b1, 1'b1);
				span(DTC_TERM_WR, 10 - p, 4 + p, 3'h2);
			join
		end
	endtask : t_write
	task automatic t_read;
		for (int f = 0; f < 2; f++) begin
			reg_wr(8'h0C, 32'h0001_6009 | (f << 20));
			fork
				ctl.issue(1'b1, 1'b0, 1'b0);
				span(DTC_TERM_OFF, 11, 6 - 2 * f, 3'h0);
			join
		end
	endtask : t_read
	task automatic t_ignore;
		reg_wr(8'h00, 32'h0000_0000);
		fork
			ctl.drive_pin(8);
			repeat (14) begin
				@(posedge mclk);
				#1;
				chk("ignored", DTC_TERM_PARK, term.state);
			end
		join
		chk("rx off", 1'b0, pin_rx_enable);
	endtask : t_ignore
	task automatic t_power;
		reg_wr(8'h00, 32'h0000_0300);
		fork
			ctl.drive_pin(30);
			begin
				repeat (12) @(posedge mclk);
				self_refresh <= 1'b1;
				repeat (2) @(posedge mclk);
				#1;
				chk("sr", DTC_TERM_OFF, term.state);
				chk("sr rx", 1'b0, pin_rx_enable);
				self_refresh <= 1'b0;
				dll_locked <= 1'b0;
				repeat (2) @(posedge mclk);
				#1;
				chk("dll", DTC_TERM_OFF, term.state);
				dll_locked <= 1'b1;
			end
		join
	endtask : t_power
	task automatic t_status;
		reg_wr(8'h0C, 32'h0019_6009);
		repeat (12) @(posedge mclk);
		reg_rd(8'h10, 32'h0000_006B);
		@(posedge mclk);
		#1;
		chk("rdata idle", 32'h0000_0000, bus_rdata);
		ctl.pulse_pin(2);
		repeat (12) @(posedge mclk);
		reg_rd(8'h10, 32'h0000_007B);
		reg_wr(8'h10, 32'h0000_0010);
		reg_rd(8'h10, 32'h0000_006B);
	endtask : t_status
	task automatic t_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk("reset state", DTC_TERM_OFF, term.state);
		chk("reset rx", 1'b0, pin_rx_enable);
		reg_rd(8'h0C, 32'h0000_0009);
		reg_rd(8'h10, 32'h0000_0040);
	endtask : t_reset
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		t_regs();
		t_nominal();
		t_write();
		t_read();
		t_ignore();
		t_power();
		t_status();
		t_reset();
		test_done();
	end
	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		test_done();
	end
endmodule : dtc_tb_top
